// >>> dv/sfb_core_bench.sv
// self-checking bench for the subtract and sleep core
`timescale 1ns/100ps
module sfb_core_bench;
  logic pclk, presetn, ce, psel, penable, pwrite, wake_pin, pready, pslverr, sleeping;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] expq[$];
  int fail_count = 0;
  int n_compared = 0;
  sfb_core #(.WDT_POST_DIV(2)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin), .sleeping(sleeping));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // request stands until pready is seen at a rising edge; the watchdog ends a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so the next call never reassigns psel in the same step
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task wait_awake(input int lim);
    int n;
    n = 0;
    while (sleeping !== 1'b0 && n < lim) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
    if (n >= lim) fail_count++;
  endtask
  always @(posedge pclk) begin
    if (presetn && psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      chk({pslverr, prdata}, expq.pop_front());
  end
  initial begin
    #40000;
    fail_count++;
    wrap_up;
  end
  initial begin
    logic [7:0] w, fv, r, f, keep;
    logic [8:0] s;
    logic [4:0] h, fl;
    logic [11:0] ea, base;
    logic [3:0] bk;
    logic c, d, a, ext;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wake_pin = 1'b0;
    void'($urandom(9105));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h18, 33'h3);
    for (int i = 0; i < 16; i++) begin
      w = 8'($urandom);
      fv = 8'($urandom);
      {c, d, bk, base} = 18'($urandom);
      // first three pass force the indexed, high access and low access cases
      f = i == 0 ? 8'h5F : i == 1 ? 8'h60 : i == 2 ? 8'h10 : 8'($urandom);
      a = i < 3 ? 1'b0 : 1'($urandom);
      ext = i == 0 ? 1'b1 : i < 3 ? 1'b0 : 1'($urandom);
      ea = a ? {bk, f} : (ext && f <= 8'h5F) ? base + 12'(f) : f <= 8'h5F ? {4'h0, f} : {4'hF, f};
      s = {1'b0, w} + {1'b0, ~fv} + 9'(c);
      h = {1'b0, w[3:0]} + {1'b0, ~fv[3:0]} + 5'(c);
      r = s[7:0];
      fl = {r[7], (w[7] != fv[7]) && (r[7] != w[7]), r == 8'h00, h[4], s[8]};
      wr(8'h14, {31'h0, ext});
      wr(8'h0C, 32'(bk));
      wr(8'h10, 32'(base));
      wr(8'h1C, 32'(ea));
      wr(8'h20, 32'(fv));
      wr(8'h04, 32'(w));
      wr(8'h08, 32'(c));
      wr(8'h00, {16'h0, 6'b010101, d, a, f});
      rd(8'h20, 33'(d ? r : fv));
      rd(8'h04, 33'(d ? w : r));
      rd(8'h08, 33'(fl));
      keep = d ? w : r;
    end
    // a code other than subtract or sleep must leave the working register alone
    wr(8'h00, 32'h5B11);
    rd(8'h00, 33'h5B11);
    rd(8'h04, 33'(keep));
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h3);
    wr(8'h00, 32'h5400);
    wr(8'h18, 32'h0);
    rd(8'h18, 33'h6);
    wake_pin <= 1'b1;
    wait_awake(50);
    repeat (4) @(posedge pclk);
    wake_pin <= 1'b0;
    rd(8'h18, 33'h2);
    rd(8'h04, 33'(keep));
    wr(8'h14, 32'h2);
    wr(8'h00, 32'h3);
    // read stalls until the sleep has landed, so the wait below cannot pass early
    rd(8'h18, 33'h6);
    wait_awake(2000);
    rd(8'h18, 33'h0);
    rd(8'h24, 33'h100000000);
    // a transfer started while frozen must wait for ce to return
    ce <= 1'b0;
    fork
      wr(8'h04, 32'h5A);
      begin
        repeat (6) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    rd(8'h04, 33'h5A);
    rd(8'h18, 33'h0);
    wrap_up;
  end
endmodule

// >>> dv/sfb_core_checker.sv
// port assertions for the subtract and sleep core
`timescale 1ns/100ps
module sfb_core_checker #(
  parameter int WDT_POST_DIV = 128
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wake_pin,
  input wire logic sleeping
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RDY_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 !pready)
    else $error("ready before third access cycle");
  AST_ANSWER: assert property (psel && penable && !$past(penable) |-> ##[2:12] pready)
    else $error("transfer not answered");
  AST_MAP_OK: assert property (pready && paddr[1:0] == 2'h0 && paddr <= 8'h20 |-> !pslverr)
    else $error("error on mapped address");
  AST_MAP_BAD: assert property (pready && paddr > 8'h20 |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped address not refused");
  AST_CE: assert property (!ce |-> !pready)
    else $error("ready while clock enable low");
  AST_SLEEP_ENTER: assert property (pready && pwrite && paddr == 8'h00 && pwdata[15:0] == 16'h0003
    && !sleeping |-> ##[3:7] sleeping)
    else $error("sleep not entered");
  AST_WAKE: assert property ((wake_pin && ce && !(pready && paddr == 8'h00)) [*5]
    |=> !sleeping)
    else $error("wake request did not end sleep");
endmodule
bind sfb_core sfb_core_checker #(.WDT_POST_DIV(WDT_POST_DIV)) u_chk (.pclk(pclk),
  .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin),
  .sleeping(sleeping));

// >>> verilog/sfb_cfg.svh
// constants for the subtract-with-borrow and sleep execution block
// How it works
// [RULE1] result is working register minus file register minus inverted carry
// [RULE2] opcode 0101 01da ffff ffff; d clear sends the result to working register
// [RULE3] d set writes the result back into the addressed file register
// [RULE4] a clear uses the access bank; a set uses bank select register
// [RULE5] a clear, extended set on, f at most 5Fh: indexed literal offset
// [RULE6] watchdog wake from sleep clears the timeout flag
// [RULE7] sleep clears powerdown flag, sets timeout flag, clears watchdog, stops
// [RULE8] subtract updates N, OV, C, DC, Z; carry set means no borrow
`ifndef SFB_CFG_SVH
`define SFB_CFG_SVH

`define SFB_OFF_INSTR 8'h00
`define SFB_OFF_WREG 8'h04
`define SFB_OFF_STATUS 8'h08
`define SFB_OFF_BANK 8'h0C
`define SFB_OFF_IDXBASE 8'h10
`define SFB_OFF_CTRL 8'h14
`define SFB_OFF_PWR 8'h18
`define SFB_OFF_FADDR 8'h1C
`define SFB_OFF_FDATA 8'h20

`define SFB_OPC_MASK 16'hFC00
`define SFB_OPC_SUBB 16'h5400
`define SFB_OPC_SLEEP 16'h0003
`define SFB_BIT_D 9
`define SFB_BIT_A 8

`define SFB_IDX_LIMIT 8'h5F
`define SFB_ACC_LO_BANK 4'h0
`define SFB_ACC_HI_BANK 4'hF

`define SFB_ST_C 0
`define SFB_ST_DC 1
`define SFB_ST_Z 2
`define SFB_ST_OV 3
`define SFB_ST_N 4

`define SFB_CTRL_EXT 0
`define SFB_CTRL_WDT 1

`define SFB_PWR_PD 0
`define SFB_PWR_TO 1
`define SFB_PWR_SLEEP 2
`define SFB_PWR_BUSY 3
`define SFB_INSTR_BUSY 16

`define SFB_RST_PD 1'b1
`define SFB_RST_TO 1'b1
`define SFB_ACK_CNT 2'h2

`endif

// >>> verilog/sfb_core.sv
// subtract-with-borrow and sleep execution core with apb register access
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "sfb_cfg.svh"
module sfb_core #(
  parameter int WDT_POST_DIV = 128
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_pin,
  output logic sleeping
);
  import sfb_pkg::*;

  localparam logic [15:0] POST_LAST = 16'(WDT_POST_DIV - 1);

  sfb_state_t s_r;
  sfb_state_t s_nxt;
  logic ram_we;
  logic [11:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic wdt_to;
  logic hit;
  logic [31:0] rd_val;

  // two's complement subtract, borrow is the inverted carry
  function automatic logic [12:0] sub_borrow(input logic [7:0] w, input logic [7:0] f,
                                             input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] r;
    sfb_flags_t fl;
    full = {1'b0, w} + {1'b0, ~f} + {8'h00, cin}; // [RULE1]
    low = {1'b0, w[3:0]} + {1'b0, ~f[3:0]} + {4'h0, cin};
    r = full[7:0];
    fl.c = full[8]; // [RULE8]
    fl.dc = low[4];
    fl.z = (r == 8'h00);
    fl.n = r[7];
    fl.ov = (w[7] != f[7]) && (r[7] != w[7]);
    return {fl, r};
  endfunction

  function automatic logic [11:0] file_addr(input logic [15:0] ins, input logic ext,
                                            input logic [3:0] bank, input logic [11:0] base);
    logic [7:0] f;
    f = ins[7:0];
    if (ins[`SFB_BIT_A]) begin
      file_addr = {bank, f}; // [RULE4]
    end else if (ext && f <= `SFB_IDX_LIMIT) begin
      file_addr = base + {4'h0, f}; // [RULE5]
    end else if (f <= `SFB_IDX_LIMIT) begin
      file_addr = {`SFB_ACC_LO_BANK, f}; // [RULE4]
    end else begin
      file_addr = {`SFB_ACC_HI_BANK, f};
    end
  endfunction

  sfb_file_ram #(
    .AW(12),
    .DW(8)
  ) u_ram (
    .clk(pclk),
    .ce(ce),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // register read mux and address decode
  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `SFB_OFF_INSTR: begin
        rd_val[15:0] = s_r.instr;
        rd_val[`SFB_INSTR_BUSY] = (s_r.phase != PH_IDLE);
      end
      `SFB_OFF_WREG: rd_val[7:0] = s_r.wreg;
      `SFB_OFF_STATUS: begin
        rd_val[`SFB_ST_C] = s_r.flags.c;
        rd_val[`SFB_ST_DC] = s_r.flags.dc;
        rd_val[`SFB_ST_Z] = s_r.flags.z;
        rd_val[`SFB_ST_OV] = s_r.flags.ov;
        rd_val[`SFB_ST_N] = s_r.flags.n;
      end
      `SFB_OFF_BANK: rd_val[3:0] = s_r.bank_select_reg;
      `SFB_OFF_IDXBASE: rd_val[11:0] = s_r.idx_base;
      `SFB_OFF_CTRL: begin
        rd_val[`SFB_CTRL_EXT] = s_r.ext_en;
        rd_val[`SFB_CTRL_WDT] = s_r.wdt_en;
      end
      `SFB_OFF_PWR: begin
        rd_val[`SFB_PWR_PD] = s_r.powerdown_flag;
        rd_val[`SFB_PWR_TO] = s_r.timeout_flag;
        rd_val[`SFB_PWR_SLEEP] = s_r.sleeping;
        rd_val[`SFB_PWR_BUSY] = (s_r.phase != PH_IDLE);
      end
      `SFB_OFF_FADDR: rd_val[11:0] = s_r.faddr;
      `SFB_OFF_FDATA: rd_val[7:0] = ram_rdata;
      default: hit = 1'b0;
    endcase
  end

  // ce gating keeps a frozen block from completing a transfer
  assign pready = ce && psel && penable && (s_r.ack_cnt == `SFB_ACK_CNT);
  assign pslverr = pready && !hit;
  assign prdata = s_r.prdata;
  assign sleeping = s_r.sleeping;

  always_comb begin
    s_nxt = s_r;
    ram_we = 1'b0;
    ram_addr = s_r.faddr;
    ram_wdata = pwdata[7:0];
    wdt_to = 1'b0;
    s_nxt.wake_s1 = wake_pin;
    s_nxt.wake_s2 = s_r.wake_s1;

    // watchdog: postscaler divides the clock, counter overflow is a timeout
    if (s_r.wdt_en) begin
      if (s_r.wdt_post == POST_LAST) begin
        s_nxt.wdt_post = 16'h0000;
        s_nxt.watchdog_counter = s_r.watchdog_counter + 8'h01;
        wdt_to = (s_r.watchdog_counter == 8'hFF);
      end else begin
        s_nxt.wdt_post = s_r.wdt_post + 16'h0001;
      end
    end
    if (s_r.sleeping) begin
      if (wdt_to) begin
        s_nxt.sleeping = 1'b0;
        s_nxt.timeout_flag = 1'b0; // [RULE6]
      end else if (s_r.wake_s2) begin
        s_nxt.sleeping = 1'b0;
      end
    end

    // one instruction cycle, four quarter phases
    unique case (s_r.phase)
      PH_IDLE: begin
      end
      PH_Q1: begin
        s_nxt.ex_addr = file_addr(s_r.instr, s_r.ext_en, s_r.bank_select_reg, s_r.idx_base);
        s_nxt.phase = PH_Q2;
      end
      PH_Q2: begin
        ram_addr = s_r.ex_addr;
        s_nxt.phase = PH_Q3;
      end
      PH_Q3: begin
        ram_addr = s_r.ex_addr;
        {s_nxt.res_flags, s_nxt.res} = sub_borrow(s_r.wreg, ram_rdata, s_r.flags.c); // [RULE1]
        s_nxt.phase = PH_Q4;
      end
      PH_Q4: begin
        s_nxt.phase = PH_IDLE;
        if ((s_r.instr & `SFB_OPC_MASK) == `SFB_OPC_SUBB) begin // [RULE2]
          s_nxt.flags = s_r.res_flags; // [RULE8]
          if (s_r.instr[`SFB_BIT_D]) begin
            ram_addr = s_r.ex_addr;
            ram_wdata = s_r.res;
            ram_we = 1'b1; // [RULE3]
          end else begin
            s_nxt.wreg = s_r.res; // [RULE2]
          end
        end else if (s_r.instr == `SFB_OPC_SLEEP) begin
          s_nxt.powerdown_flag = 1'b0; // [RULE7]
          s_nxt.timeout_flag = 1'b1; // [RULE7]
          s_nxt.watchdog_counter = 8'h00; // [RULE7]
          s_nxt.wdt_post = 16'h0000; // [RULE7]
          s_nxt.sleeping = 1'b1; // [RULE7]
        end
      end
    endcase

    // apb: stalls while an instruction runs so nothing collides with phase q4
    if (psel && penable && s_r.phase == PH_IDLE) begin
      if (s_r.ack_cnt == `SFB_ACK_CNT) begin
        s_nxt.ack_cnt = 2'h0;
        if (pwrite) begin
          unique case (paddr)
            `SFB_OFF_INSTR: begin
              // a halted core ignores new instructions
              if (!s_r.sleeping) begin
                s_nxt.instr = pwdata[15:0];
                s_nxt.phase = PH_Q1;
              end
            end
            `SFB_OFF_WREG: s_nxt.wreg = pwdata[7:0];
            `SFB_OFF_STATUS: begin
              s_nxt.flags.c = pwdata[`SFB_ST_C];
              s_nxt.flags.dc = pwdata[`SFB_ST_DC];
              s_nxt.flags.z = pwdata[`SFB_ST_Z];
              s_nxt.flags.ov = pwdata[`SFB_ST_OV];
              s_nxt.flags.n = pwdata[`SFB_ST_N];
            end
            `SFB_OFF_BANK: s_nxt.bank_select_reg = pwdata[3:0];
            `SFB_OFF_IDXBASE: s_nxt.idx_base = pwdata[11:0];
            `SFB_OFF_CTRL: begin
              s_nxt.ext_en = pwdata[`SFB_CTRL_EXT];
              s_nxt.wdt_en = pwdata[`SFB_CTRL_WDT];
            end
            `SFB_OFF_FADDR: s_nxt.faddr = pwdata[11:0];
            `SFB_OFF_FDATA: ram_we = 1'b1;
            default: begin
            end
          endcase
        end
      end else begin
        // first wait lets the memory read settle, second captures it
        if (s_r.ack_cnt == 2'h1) begin
          s_nxt.prdata = rd_val;
        end
        s_nxt.ack_cnt = s_r.ack_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.phase <= PH_IDLE;
      s_r.powerdown_flag <= `SFB_RST_PD;
      s_r.timeout_flag <= `SFB_RST_TO;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end
endmodule

// >>> verilog/sfb_file_ram.sv
// byte-wide file register memory with registered read data
`timescale 1ns/100ps
module sfb_file_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset on purpose: contents are undefined after power-up, like real sram
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule

// >>> verilog/sfb_pkg.sv
// types for the subtract-with-borrow and sleep execution block
package sfb_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} sfb_phase_t;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } sfb_flags_t;

  typedef struct packed {
    sfb_phase_t phase;
    logic [15:0] instr;
    logic [11:0] ex_addr;
    logic [7:0] res;
    sfb_flags_t res_flags;
    logic [7:0] wreg;
    sfb_flags_t flags;
    logic [3:0] bank_select_reg;
    logic [11:0] idx_base;
    logic ext_en;
    logic wdt_en;
    logic timeout_flag;
    logic powerdown_flag;
    logic sleeping;
    logic [7:0] watchdog_counter;
    logic [15:0] wdt_post;
    logic wake_s1;
    logic wake_s2;
    logic [11:0] faddr;
    logic [1:0] ack_cnt;
    logic [31:0] prdata;
  } sfb_state_t;
endpackage
